// File: inc/acmp_pkg.sv
// acmp_pkg: register map, field layout, modes and shared types for the
// comparator control block.
// assumes: a 32-bit Avalon-MM slave port with byte addresses.
package acmp_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int ACMP_VW     = 10;  // width of a modelled analog level
    localparam int ACMP_ADDR_W = 4;
    localparam int ACMP_DATA_W = 32;
    localparam int ACMP_NCHAN  = 8;
    localparam int ACMP_SEL_W  = 3;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ACMP_ADDR_W-1:0] ACMP_OFS_CONV_B = 4'h0;
    localparam logic [ACMP_ADDR_W-1:0] ACMP_OFS_CSR    = 4'h4;
    localparam logic [ACMP_ADDR_W-1:0] ACMP_OFS_DID    = 4'h8;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ACMP_NEG_MUX_EN_BIT = 6;  // converter_ctrl_status_b
    localparam int ACMP_FLAG_BIT       = 4;  // comparator_ctrl_status
    localparam int ACMP_NEG_DID_BIT    = 1;  // digital_input_disable_1
    localparam int ACMP_POS_DID_BIT    = 0;
    localparam int ACMP_LANE0_BE       = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ACMP_CONV_B_RST = 8'h00;
    localparam logic [7:0] ACMP_CSR_RST    = 8'h00;
    localparam logic [7:0] ACMP_DID_RST    = 8'h00;
    localparam logic [ACMP_DATA_W-1:0] ACMP_RDATA_RST = 32'h0000_0000;

    // stand-in level for the internal reference, value is arbitrary
    localparam logic [ACMP_VW-1:0] ACMP_BANDGAP_CODE = 10'h1C2;
    // negative level when the borrowed mux is powered down: never beaten
    localparam logic [ACMP_VW-1:0] ACMP_NEG_UNAVAIL  = 10'h3FF;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACMP_MODE_ANY  = 2'b00,
        ACMP_MODE_RSVD = 2'b01,
        ACMP_MODE_FALL = 2'b10,
        ACMP_MODE_RISE = 2'b11
    } acmp_mode_t;

    // laid out in bit order 7 downto 0
    typedef struct packed {
        logic       comparator_disable;
        logic       bandgap_select;
        logic       comparator_output_bit;
        logic       comparator_event_flag;
        logic       comparator_irq_enable;
        logic       capture_route_enable;
        acmp_mode_t event_mode;
    } acmp_csr_t;

    typedef struct packed {
        logic                   read;
        logic                   write;
        logic [ACMP_ADDR_W-1:0] address;
        logic [ACMP_DATA_W-1:0] writedata;
        logic [3:0]             byteenable;
    } acmp_avm_req_t;

    // ------------------------------------------------------------------
    // edge decision shared by event and capture detection
    // ------------------------------------------------------------------
    function automatic logic acmp_edge_hit(input acmp_mode_t mode,
                                           input logic       prev,
                                           input logic       cur);
        logic hit;
        hit = 1'b0;
        case (mode)
            ACMP_MODE_ANY:  hit = prev ^ cur;
            ACMP_MODE_FALL: hit = prev & ~cur;
            ACMP_MODE_RISE: hit = ~prev & cur;
            default:        hit = 1'b0;  // reserved code flags nothing
        endcase
        return hit;
    endfunction

endpackage

// File: verilog/acmp_sync.sv
// acmp_sync: two-stage synchroniser for asynchronous single-bit levels.
// assumes: each bit is an independent level; no word coherency.
`timescale 1ns/1ps
module acmp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output wire logic [W-1:0] o_sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // meta_q is read only by sync_q
    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;

endmodule // acmp_sync

// File: verilog/acmp_evt.sv
// acmp_evt: transition detector on a synchronised level, selectable edge.
// assumes: i_level is already in the i_ref_clk domain.
`timescale 1ns/1ps
module acmp_evt (
    input  wire logic                i_ref_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_level,
    input  wire logic                i_enable,
    input  wire acmp_pkg::acmp_mode_t i_mode,
    output wire logic                o_hit
);

    logic prev_q;
    logic prev_d;

    // previous level keeps tracking while disabled, so enabling only
    // reports transitions that happen afterwards
    always_comb begin
        prev_d = i_level;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign o_hit = i_enable & acmp_pkg::acmp_edge_hit(i_mode, prev_q, i_level);

endmodule // acmp_evt

// File: verilog/acmp_ctrl.sv
// acmp_ctrl: control logic around an analog comparator: input selection,
// output synchroniser, event flag and interrupt, capture routing and
// digital input buffer disables, with an Avalon-MM register slave.
// assumes: analog levels are modelled as unsigned codes; converter enable,
// channel select, power reduction and timer mask come from logic on
// i_ref_clk; pin digital levels are asynchronous.
//
// Behaviour
// - output high when positive exceeds negative
// - mux on, converter off: channel picks negative
// - otherwise dedicated negative pin is used
// - bandgap select replaces positive input pin
// - result synchronised, one to two cycles
// - flag set on selected edge, irq-independent
// - mode: toggle, reserved, falling, rising
// - irq while flag, enable, global enable
// - flag cleared by vector or writing one
// - disable bit stops all comparison activity; here capture edge detect and mux borrow stay live
// - capture route feeds timer capture front end
// - capture interrupt needs timer capture mask
// - input disable kills buffer, port reads zero
// - power reduction blocks borrowed negative mux
// - converter enabled owns its channel mux
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module acmp_ctrl (
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_rst_n,
    // register bus
    input  wire acmp_pkg::acmp_avm_req_t   i_avm,
    output wire logic [31:0]               o_avm_readdata,
    output wire logic                      o_avm_waitrequest,
    // modelled analog levels
    input  wire logic [9:0]                i_positive_input_pin,
    input  wire logic [9:0]                i_negative_input_pin,
    input  wire logic [7:0][9:0]           i_analog_channels,
    // converter and system context
    input  wire logic                      i_converter_enable,
    input  wire logic [2:0]                i_channel_select_bits,
    input  wire logic                      i_converter_power_reduction,
    input  wire logic                      i_global_irq_enable,
    input  wire logic                      i_irq_vector_ack,
    input  wire logic                      i_timer_capture_irq_mask,
    input  wire logic                      i_capture_edge_rising,
    // pin digital levels
    input  wire logic                      i_pos_pin_digital,
    input  wire logic                      i_neg_pin_digital,
    // results
    output wire logic                      o_comparator_irq,
    output wire logic                      o_capture_trigger,
    output wire logic                      o_capture_irq,
    output wire logic                      o_negative_mux_active,
    output wire logic                      o_comparator_powered,
    output wire logic                      o_pos_pin_port_bit,
    output wire logic                      o_neg_pin_port_bit,
    output wire logic                      o_pos_pin_buffer_en,
    output wire logic                      o_neg_pin_buffer_en
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    acmp_pkg::acmp_csr_t        csr_q;
    acmp_pkg::acmp_csr_t        csr_d;
    acmp_pkg::acmp_csr_t        csr_rd;
    logic                       neg_mux_en_q;
    logic                       neg_mux_en_d;
    logic [1:0]                 did_q;
    logic [1:0]                 did_d;
    logic                       wait_q;
    logic                       wait_d;
    logic [31:0]                rdata_q;
    logic [31:0]                rdata_d;
    logic                       irq_q;
    logic                       irq_d;
    logic                       cap_trig_q;
    logic                       cap_trig_d;
    logic                       cap_irq_q;
    logic                       cap_irq_d;
    logic                       mux_act_q;
    logic                       mux_act_d;
    logic                       powered_q;
    logic                       powered_d;
    logic [1:0]                 port_q;
    logic [1:0]                 port_d;
    logic [1:0]                 buf_en_q;
    logic [1:0]                 buf_en_d;

    logic                       req;
    logic                       wr_acc;
    logic                       wr_conv_b;
    logic                       wr_csr;
    logic                       wr_did;
    logic                       mux_borrow;
    logic [9:0]                 pos_level;
    logic [9:0]                 neg_level;
    logic                       raw_result;
    logic                       aco_sync;
    logic                       pos_dig_sync;
    logic                       neg_dig_sync;
    logic                       evt_hit;
    logic                       cap_hit;
    acmp_pkg::acmp_mode_t       cap_mode;

    // ------------------------------------------------------------------
    // comparator input selection
    // ------------------------------------------------------------------
    // the converter only lends its mux while it is switched off
    assign mux_borrow = neg_mux_en_q & ~i_converter_enable;

    always_comb begin
        pos_level = csr_q.bandgap_select ? acmp_pkg::ACMP_BANDGAP_CODE
                                         : i_positive_input_pin;
        if (!mux_borrow) begin
            neg_level = i_negative_input_pin;
        end else if (i_converter_power_reduction) begin
            // powered-down mux gives no level the input can beat
            neg_level = acmp_pkg::ACMP_NEG_UNAVAIL;
        end else begin
            neg_level = i_analog_channels[i_channel_select_bits];
        end
        // stands for the analog compare; forced low while switched off
        raw_result = ~csr_q.comparator_disable
                     & (pos_level > neg_level);
    end

    // ------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------
    acmp_sync #(
        .W (3)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_async   ({raw_result, i_pos_pin_digital, i_neg_pin_digital}),
        .o_sync    ({aco_sync, pos_dig_sync, neg_dig_sync})
    );

    // ------------------------------------------------------------------
    // event and capture edge detection
    // ------------------------------------------------------------------
    acmp_evt u_evt (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_level   (aco_sync),
        .i_enable  (~csr_q.comparator_disable),
        .i_mode    (csr_q.event_mode),
        .o_hit     (evt_hit)
    );

    // the timer's edge select picks rising or falling only
    assign cap_mode = i_capture_edge_rising ? acmp_pkg::ACMP_MODE_RISE
                                            : acmp_pkg::ACMP_MODE_FALL;

    acmp_evt u_cap (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_level   (aco_sync),
        .i_enable  (csr_q.capture_route_enable),
        .i_mode    (cap_mode),
        .o_hit     (cap_hit)
    );

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    // one wait cycle per access: the request is seen with waitrequest
    // high, then answered with waitrequest low for one cycle
    assign req       = i_avm.read | i_avm.write;
    assign wr_acc    = i_avm.write & ~wait_q
                       & i_avm.byteenable[acmp_pkg::ACMP_LANE0_BE];
    assign wr_conv_b = wr_acc & (i_avm.address == acmp_pkg::ACMP_OFS_CONV_B);
    assign wr_csr    = wr_acc & (i_avm.address == acmp_pkg::ACMP_OFS_CSR);
    assign wr_did    = wr_acc & (i_avm.address == acmp_pkg::ACMP_OFS_DID);

    always_comb begin
        csr_rd                       = csr_q;
        csr_rd.comparator_output_bit = aco_sync;
        wait_d  = ~(req & wait_q);
        rdata_d = rdata_q;
        if (i_avm.read & wait_q) begin
            rdata_d = acmp_pkg::ACMP_RDATA_RST;  // unmapped reads zero
            case (i_avm.address)
                acmp_pkg::ACMP_OFS_CONV_B:
                    rdata_d[acmp_pkg::ACMP_NEG_MUX_EN_BIT] = neg_mux_en_q;
                acmp_pkg::ACMP_OFS_CSR:
                    rdata_d[7:0] = csr_rd;
                acmp_pkg::ACMP_OFS_DID:
                    rdata_d[1:0] = did_q;
                default:
                    rdata_d = acmp_pkg::ACMP_RDATA_RST;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_comb begin
        csr_d        = csr_q;
        neg_mux_en_d = neg_mux_en_q;
        did_d        = did_q;
        if (wr_conv_b) begin
            neg_mux_en_d = i_avm.writedata[acmp_pkg::ACMP_NEG_MUX_EN_BIT];
        end
        if (wr_did) begin
            did_d = i_avm.writedata[1:0];
        end
        if (wr_csr) begin
            // mode and disable changes are not masked against spurious
            // events; software drops the irq enable around them
            csr_d.comparator_disable    = i_avm.writedata[7];
            csr_d.bandgap_select        = i_avm.writedata[6];
            csr_d.comparator_irq_enable = i_avm.writedata[3];
            csr_d.capture_route_enable  = i_avm.writedata[2];
            csr_d.event_mode = acmp_pkg::acmp_mode_t'(
                i_avm.writedata[1:0]);
        end
        csr_d.comparator_output_bit = 1'b0;  // read-only, not stored
        // a zero written to the flag leaves it alone
        if ((wr_csr & i_avm.writedata[acmp_pkg::ACMP_FLAG_BIT])
            | i_irq_vector_ack) begin
            csr_d.comparator_event_flag = 1'b0;
        end
        // a new event wins over a clear in the same cycle
        if (evt_hit) begin
            csr_d.comparator_event_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_comb begin
        irq_d      = csr_q.comparator_event_flag
                     & csr_q.comparator_irq_enable
                     & i_global_irq_enable;
        cap_trig_d = csr_q.capture_route_enable & aco_sync;
        cap_irq_d  = cap_hit & i_timer_capture_irq_mask;
        mux_act_d  = mux_borrow & ~i_converter_power_reduction;
        powered_d  = ~csr_q.comparator_disable;
        buf_en_d   = ~did_q;
        port_d     = {neg_dig_sync, pos_dig_sync} & ~did_q;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            csr_q        <= acmp_pkg::acmp_csr_t'(acmp_pkg::ACMP_CSR_RST);
            neg_mux_en_q <= acmp_pkg::ACMP_CONV_B_RST[6];
            did_q        <= acmp_pkg::ACMP_DID_RST[1:0];
            wait_q       <= 1'b1;
            rdata_q      <= acmp_pkg::ACMP_RDATA_RST;
            irq_q        <= 1'b0;
            cap_trig_q   <= 1'b0;
            cap_irq_q    <= 1'b0;
            mux_act_q    <= 1'b0;
            powered_q    <= 1'b0;
            port_q       <= 2'b00;
            buf_en_q     <= 2'b00;
        end else begin
            csr_q        <= csr_d;
            neg_mux_en_q <= neg_mux_en_d;
            did_q        <= did_d;
            wait_q       <= wait_d;
            rdata_q      <= rdata_d;
            irq_q        <= irq_d;
            cap_trig_q   <= cap_trig_d;
            cap_irq_q    <= cap_irq_d;
            mux_act_q    <= mux_act_d;
            powered_q    <= powered_d;
            port_q       <= port_d;
            buf_en_q     <= buf_en_d;
        end
    end

    assign o_avm_readdata        = rdata_q;
    assign o_avm_waitrequest     = wait_q;
    assign o_comparator_irq      = irq_q;
    assign o_capture_trigger     = cap_trig_q;
    assign o_capture_irq         = cap_irq_q;
    assign o_negative_mux_active = mux_act_q;
    assign o_comparator_powered  = powered_q;
    assign o_pos_pin_port_bit    = port_q[acmp_pkg::ACMP_POS_DID_BIT];
    assign o_neg_pin_port_bit    = port_q[acmp_pkg::ACMP_NEG_DID_BIT];
    assign o_pos_pin_buffer_en   = buf_en_q[acmp_pkg::ACMP_POS_DID_BIT];
    assign o_neg_pin_buffer_en   = buf_en_q[acmp_pkg::ACMP_NEG_DID_BIT];

endmodule // acmp_ctrl

// File: sim/acmp_ctrl_props.sv
// acmp_ctrl_props: concurrent checks on the ports of acmp_ctrl.
// assumes: one clock, async active-low reset.
`timescale 1ns/1ps
module acmp_ctrl_props (
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rst_n,
    input  wire acmp_pkg::acmp_avm_req_t i_avm,
    input  wire logic                    o_avm_waitrequest,
    input  wire logic                    i_converter_enable,
    input  wire logic                    i_converter_power_reduction,
    input  wire logic                    i_global_irq_enable,
    input  wire logic                    i_timer_capture_irq_mask,
    input  wire logic                    o_comparator_irq,
    input  wire logic                    o_capture_irq,
    input  wire logic                    o_negative_mux_active,
    input  wire logic                    o_comparator_powered,
    input  wire logic                    o_pos_pin_port_bit,
    input  wire logic                    o_neg_pin_port_bit,
    input  wire logic                    o_pos_pin_buffer_en,
    input  wire logic                    o_neg_pin_buffer_en
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic wr_done;
    assign wr_done = i_avm.write & ~o_avm_waitrequest;
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    chk_bus_wait: assert property (
        (i_avm.read | i_avm.write) && o_avm_waitrequest |=> !o_avm_waitrequest)
        else $error("no answer after one wait");
    chk_wait_pulse: assert property (!o_avm_waitrequest |=> o_avm_waitrequest)
        else $error("waitrequest low too long");
    chk_irq_global: assert property (
        o_comparator_irq |-> $past(i_global_irq_enable))
        else $error("irq without global enable");
    chk_irq_drop: assert property (
        $fell(i_global_irq_enable) |=> !o_comparator_irq)
        else $error("irq after global disable");
    chk_mux_gate: assert property (
        o_negative_mux_active |->
        $past(!i_converter_enable && !i_converter_power_reduction))
        else $error("mux active while owned");
    chk_cap_mask: assert property (
        o_capture_irq |-> $past(i_timer_capture_irq_mask))
        else $error("capture irq while masked");
    chk_cap_pulse: assert property (o_capture_irq |=> !o_capture_irq)
        else $error("capture irq too long");
    chk_pos_zero: assert property (
        !o_pos_pin_buffer_en |-> !o_pos_pin_port_bit)
        else $error("pos port bit with buffer off");
    chk_neg_zero: assert property (
        !o_neg_pin_buffer_en |-> !o_neg_pin_port_bit)
        else $error("neg port bit with buffer off");
    chk_pwr_write: assert property (
        $past(i_rst_n, 2) && $changed(o_comparator_powered)
        |-> $past(wr_done) || $past(wr_done, 2))
        else $error("power change without write");
endmodule // acmp_ctrl_props

bind acmp_ctrl acmp_ctrl_props u_props (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_avm(i_avm),
    .o_avm_waitrequest(o_avm_waitrequest),
    .i_converter_enable(i_converter_enable),
    .i_converter_power_reduction(i_converter_power_reduction),
    .i_global_irq_enable(i_global_irq_enable),
    .i_timer_capture_irq_mask(i_timer_capture_irq_mask),
    .o_comparator_irq(o_comparator_irq), .o_capture_irq(o_capture_irq),
    .o_negative_mux_active(o_negative_mux_active),
    .o_comparator_powered(o_comparator_powered),
    .o_pos_pin_port_bit(o_pos_pin_port_bit),
    .o_neg_pin_port_bit(o_neg_pin_port_bit),
    .o_pos_pin_buffer_en(o_pos_pin_buffer_en),
    .o_neg_pin_buffer_en(o_neg_pin_buffer_en)
);

// File: sim/acmp_ctrl_tb.sv
// acmp_ctrl_tb: register-level self-checking bench for acmp_ctrl.
// assumes: design files and acmp_ctrl_props compiled beforehand.
`timescale 1ns/1ps
module acmp_ctrl_tb;
    logic                    clk = 1'b0;
    logic                    rst_n = 1'b0;
    acmp_pkg::acmp_avm_req_t avm = '0;
    logic [31:0]             rdata, v;
    logic                    wrq, irq, ctrig, cirq, mux_act, pwr;
    logic                    pport, nport, pbuf, nbuf;
    logic [9:0]              pos = 10'h100, neg = 10'h200;
    logic [7:0][9:0]         ch = '0;
    logic [2:0]              sel = 3'h0;
    logic                    conv_en = 1'b0, pr = 1'b0, gie = 1'b0;
    logic                    ack = 1'b0, mask = 1'b0, pdig = 1'b0, ndig = 1'b0;
    int                      error_cnt = 0, n_tests = 0, cap_cnt = 0;
    localparam logic [9:0]   BG = acmp_pkg::ACMP_BANDGAP_CODE;
    always #2 clk = ~clk;

    acmp_ctrl dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_avm(avm),
        .o_avm_readdata(rdata), .o_avm_waitrequest(wrq),
        .i_positive_input_pin(pos), .i_negative_input_pin(neg),
        .i_analog_channels(ch), .i_converter_enable(conv_en),
        .i_channel_select_bits(sel), .i_converter_power_reduction(pr),
        .i_global_irq_enable(gie), .i_irq_vector_ack(ack),
        .i_timer_capture_irq_mask(mask), .i_capture_edge_rising(1'b1),
        .i_pos_pin_digital(pdig), .i_neg_pin_digital(ndig),
        .o_comparator_irq(irq), .o_capture_trigger(ctrig),
        .o_capture_irq(cirq), .o_negative_mux_active(mux_act),
        .o_comparator_powered(pwr), .o_pos_pin_port_bit(pport),
        .o_neg_pin_port_bit(nport), .o_pos_pin_buffer_en(pbuf),
        .o_neg_pin_buffer_en(nbuf));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one Avalon access; read data lands in v
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        int n;
        n = 0;
        avm <= '{read: !wr, write: wr, address: a, writedata: d,
                 byteenable: 4'hF};
        do begin
            @(posedge clk);
            n++;
        end while (wrq !== 1'b0 && n < 20);
        v = rdata;
        if (n >= 20) begin
            error_cnt++;
            close_out();
        end
        avm <= '0;
        @(posedge clk);
    endtask
    // six edges cover sync, flag and irq stages
    task automatic settle();
        repeat (6) begin
            @(posedge clk);
            cap_cnt += int'(cirq === 1'b1);
        end
    endtask
    task automatic sbit(string nm, int b, logic exp);
        settle();
        bus(0, 4'h4, 32'h0);
        chk(nm, 32'(v[b]), 32'(exp));
    endtask
    function automatic logic [7:0][9:0] pat(int k);
        pat = {8{10'h3F0}};
        pat[k] = 10'h010;
    endfunction
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            bus(0, 4'(4 * i), 32'h0);
            chk("reset value", v, 32'h0);
        end
        bus(1, 4'h0, 32'hFFFF_FFFF);
        bus(0, 4'h0, 32'h0);
        chk("conv_b", v, 32'h40);
        bus(1, 4'h8, 32'hFFFF_FFFF);
        bus(0, 4'h8, 32'h0);
        chk("did", v, 32'h3);
        $display("test registers done");
        pos <= 10'h200;
        neg <= 10'h3FF;
        for (int k = 0; k < 8; k++) begin
            ch <= pat(k);
            sel <= 3'(k);
            sbit("mux select", 5, 1'b1);
            chk("mux active", 32'(mux_act), 32'h1);
        end
        pos <= 10'h010;
        sbit("equal levels", 5, 1'b0);
        pos <= 10'h200;
        conv_en <= 1'b1;
        sbit("converter owns mux", 5, 1'b0);
        conv_en <= 1'b0;
        pr <= 1'b1;
        sbit("mux powered down", 5, 1'b0);
        pr <= 1'b0;
        bus(1, 4'h0, 32'h0);
        pos <= 10'h0;
        neg <= BG - 10'h1;
        bus(1, 4'h4, 32'h40);
        sbit("bandgap above", 5, 1'b1);
        neg <= BG;
        sbit("bandgap equal", 5, 1'b0);
        $display("test input select done");
        pos <= 10'h100;
        neg <= 10'h200;
        for (int m = 0; m < 4; m++) begin
            settle();
            bus(1, 4'h4, 32'h10 | 32'(m));
            pos <= 10'h300;
            sbit("rise flag", 4, 1'(4'b1001 >> m));
            bus(1, 4'h4, 32'h10 | 32'(m));
            pos <= 10'h100;
            sbit("fall flag", 4, 1'(4'b0101 >> m));
        end
        gie <= 1'b1;
        mask <= 1'b1;
        bus(1, 4'h4, 32'h1F);
        cap_cnt = 0;
        pos <= 10'h300;
        settle();
        chk("irq raised", 32'(irq), 32'h1);
        chk("capture route", 32'(ctrig), 32'h1);
        chk("capture irq", 32'(cap_cnt), 32'h1);
        bus(1, 4'h4, 32'h0F);
        bus(0, 4'h4, 32'h0);
        chk("write zero keeps flag", 32'(v[4]), 32'h1);
        gie <= 1'b0;
        settle();
        chk("irq global off", 32'(irq), 32'h0);
        gie <= 1'b1;
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        sbit("vector clears flag", 4, 1'b0);
        chk("irq after clear", 32'(irq), 32'h0);
        mask <= 1'b0;
        pos <= 10'h100;
        settle();
        cap_cnt = 0;
        pos <= 10'h300;
        settle();
        chk("capture masked", 32'(cap_cnt), 32'h0);
        bus(1, 4'h4, 32'h13);
        settle();
        chk("route off", 32'(ctrig), 32'h0);
        $display("test events done");
        bus(1, 4'h4, 32'h93);
        sbit("disabled output", 5, 1'b0);
        chk("powered off", 32'(pwr), 32'h0);
        pos <= 10'h100;
        settle();
        pos <= 10'h300;
        sbit("no event disabled", 4, 1'b0);
        bus(1, 4'h4, 32'h13);
        @(posedge clk);
        chk("powered on", 32'(pwr), 32'h1);
        pdig <= 1'b1;
        ndig <= 1'b1;
        settle();
        chk("port bits off", {pport, nport, pbuf, nbuf}, 32'h0);
        bus(1, 4'h8, 32'h0);
        settle();
        chk("port bits on", {pport, nport, pbuf, nbuf}, 32'hF);
        $display("test disable done");
        close_out();
    end
endmodule // acmp_ctrl_tb
